/* rtl/ntrt_translate.sv */
// Functional notes
// - look up requester id plus partition
// - no match makes request unsupported
// - compare id against entry bus dev function_field
// - partition of receiving endpoint must match entry
// - match needs valid, id and partition
// - bus becomes destination captured bus
// - device bit4 set, low bits entry number
// - bypass skips lookup for posted requests
// - bypass posted id becomes bus, dev0 fn3
// - destination bus master off means unsupported
// - punch-through completion only while in progress
// - completion to own id is unexpected
// - tag 10 and valid index translate
// - completion requester id from entry
// - completer id is emitting endpoint id
// - forwarding disabled drops translated completions
// - function reset clears forwarding enable
// - capture read returns zero-extended requester id
// - capture read via window, writes ignored
// - entry fields valid function_field dev bus part
// - table holds 64 shared entries
`timescale 1ns/10ps
`default_nettype none
`include "ntrt_consts.svh"
module ntrt_translate
   import ntrt_pkg::*;
#(
   parameter int DEPTH = `NTRT_TABLE_DEPTH,
   parameter int FIFO_DEPTH = 16
)
(
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic FUNCTION_FIELD_RESET_IN,
   // table programming port
   input wire logic TBL_WE_IN,
   input wire logic [5:0] TBL_ADDR_IN,
   input wire logic [`NTRT_ENT_WIDTH-1:0] TBL_WDATA_IN,
   // endpoint and destination state
   input wire logic [2:0] SRC_PART_IN,
   input wire logic [15:0] OWN_ID_IN,
   input wire logic [15:0] PUNCH_ID_IN,
   input wire logic PUNCH_ACTIVE_IN,
   input wire logic ID_CHECK_BYPASS_IN,
   input wire logic CPL_FWD_ENABLE_SET_IN,
   input wire logic CPL_FWD_ENABLE_CLR_IN,
   input wire logic [15:0] DST_ID_IN,
   input wire logic DST_BUS_MASTER_ENABLE_IN,
   // incoming header
   input wire logic IN_VALID_IN,
   output logic IN_READY_OUT,
   input wire logic [1:0] IN_KIND_IN,
   input wire logic [15:0] IN_REQ_ID_IN,
   input wire logic [15:0] IN_CPL_ID_IN,
   input wire logic CAP_WRITE_IN,
   // outgoing header
   output logic OUT_VALID_OUT,
   input wire logic OUT_READY_IN,
   output logic [1:0] OUT_RESULT_OUT,
   output logic [1:0] OUT_KIND_OUT,
   output logic [15:0] OUT_REQ_ID_OUT,
   output logic [15:0] OUT_CPL_ID_OUT,
   output logic [31:0] OUT_CAP_DATA_OUT,
   output logic UR_PULSE_OUT,
   output logic UC_PULSE_OUT,
   output logic CPL_FWD_ENABLE_OUT,
   output logic [31:0] CAPTURE_OUT
);
   ////////////////////////////////////////////////////////////////////////
   // mapping table
   logic [`NTRT_ENT_WIDTH-1:0] table_reg [DEPTH];
   logic [DEPTH-1:0] valid_reg;
   logic [DEPTH-1:0] hit;
   always_ff @(posedge CLK_IN)
   begin
      if (TBL_WE_IN)
      begin
         table_reg[TBL_ADDR_IN] <= TBL_WDATA_IN;
      end
   end
   always_ff @(posedge CLK_IN)
   begin
      if (!RSTN_IN)
      begin
         valid_reg <= '0;
      end
      else if (TBL_WE_IN)
      begin
         valid_reg[TBL_ADDR_IN] <= TBL_WDATA_IN[`NTRT_ENT_VALID];
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_cmp
         wire id_eq = IN_REQ_ID_IN ==
            table_reg[gi][`NTRT_ENT_BUS_HI:`NTRT_ENT_FUNCTION_FIELD_LO];
         wire part_eq = SRC_PART_IN ==
            table_reg[gi][`NTRT_ENT_PART_HI:`NTRT_ENT_PART_LO];
         assign hit[gi] = valid_reg[gi] && id_eq && part_eq;
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   // match encoder
   logic [5:0] hit_idx;
   always_comb
   begin
      hit_idx = 6'h00;
      for (int i = 0; i < DEPTH; i++)
      begin
         if (hit[i])
         begin
            hit_idx = 6'(i);
         end
      end
   end
   wire any_hit = |hit;
   ////////////////////////////////////////////////////////////////////////
   // forwarding enable
   logic cpl_fwd_reg;
   always_ff @(posedge CLK_IN)
   begin
      if (!RSTN_IN || FUNCTION_FIELD_RESET_IN)
      begin
         cpl_fwd_reg <= 1'b0;
      end
      else if (CPL_FWD_ENABLE_SET_IN)
      begin
         cpl_fwd_reg <= 1'b1;
      end
      else if (CPL_FWD_ENABLE_CLR_IN)
      begin
         cpl_fwd_reg <= 1'b0;
      end
   end
   assign CPL_FWD_ENABLE_OUT = cpl_fwd_reg;
   ////////////////////////////////////////////////////////////////////////
   // request path
   wire is_posted = IN_KIND_IN == NTRT_KIND_POSTED;
   wire is_cpl = IN_KIND_IN == NTRT_KIND_CPL;
   wire is_cap = IN_KIND_IN == NTRT_KIND_CFGRD_CAP;
   wire cap_wr = is_cap && CAP_WRITE_IN;
   wire bypass = is_posted && ID_CHECK_BYPASS_IN;
   wire [15:0] req_hit_id = {DST_ID_IN[15:8], 1'b1, 1'b0, hit_idx};
   wire [15:0] req_byp_id = {DST_ID_IN[15:8], `NTRT_BYPASS_DEVFN};
   wire req_ok = bypass || any_hit;
   wire [1:0] req_res = (!req_ok || !DST_BUS_MASTER_ENABLE_IN) ?
      NTRT_RES_UR : NTRT_RES_FWD;
   wire [15:0] req_id = bypass ? req_byp_id : req_hit_id;
   ////////////////////////////////////////////////////////////////////////
   // completion path
   wire [5:0] cpl_idx = IN_REQ_ID_IN[5:0];
   wire [`NTRT_ENT_WIDTH-1:0] cpl_ent = table_reg[cpl_idx];
   wire punch_match = IN_REQ_ID_IN == PUNCH_ID_IN;
   wire own_match = IN_REQ_ID_IN == OWN_ID_IN;
   wire idx_ok = (IN_REQ_ID_IN[7:6] == `NTRT_CPL_TAG) &&
      valid_reg[cpl_idx];
   logic [1:0] cpl_res;
   always_comb
   begin
      if (punch_match)
      begin
         cpl_res = PUNCH_ACTIVE_IN ? NTRT_RES_FWD : NTRT_RES_UC;
      end
      else if (own_match || !idx_ok)
      begin
         cpl_res = NTRT_RES_UC;
      end
      else if (!cpl_fwd_reg)
      begin
         cpl_res = NTRT_RES_DROP;
      end
      else
      begin
         cpl_res = NTRT_RES_FWD;
      end
   end
   wire cpl_xlate = !punch_match && !own_match && idx_ok;
   wire [15:0] cpl_req_id = cpl_xlate ?
      cpl_ent[`NTRT_ENT_BUS_HI:`NTRT_ENT_FUNCTION_FIELD_LO] : IN_REQ_ID_IN;
   wire [15:0] cpl_cid = cpl_xlate ? DST_ID_IN : IN_CPL_ID_IN;
   ////////////////////////////////////////////////////////////////////////
   // result mux
   wire [1:0] res_sel = is_cap ? NTRT_RES_FWD :
      (is_cpl ? cpl_res : req_res);
   wire [15:0] rid_sel = is_cap ? IN_REQ_ID_IN :
      (is_cpl ? cpl_req_id : req_id);
   wire [15:0] cid_sel = is_cpl ? cpl_cid : IN_CPL_ID_IN;
   wire [31:0] cap_sel = is_cap ? {16'h0000, IN_REQ_ID_IN} : 32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////
   // capture register, read only
   logic [31:0] capture_reg;
   wire fifo_ready;
   wire take = IN_VALID_IN && fifo_ready;
   always_ff @(posedge CLK_IN)
   begin
      if (!RSTN_IN)
      begin
         capture_reg <= `NTRT_CAPTURE_RESET;
      end
      else if (take && is_cap && !CAP_WRITE_IN)
      begin
         capture_reg <= cap_sel;
      end
   end
   assign CAPTURE_OUT = capture_reg;
   ////////////////////////////////////////////////////////////////////////
   // error pulses
   logic ur_reg;
   logic uc_reg;
   always_ff @(posedge CLK_IN)
   begin
      if (!RSTN_IN)
      begin
         ur_reg <= 1'b0;
         uc_reg <= 1'b0;
      end
      else
      begin
         ur_reg <= take && !cap_wr && (res_sel == NTRT_RES_UR);
         uc_reg <= take && !cap_wr && (res_sel == NTRT_RES_UC);
      end
   end
   assign UR_PULSE_OUT = ur_reg;
   assign UC_PULSE_OUT = uc_reg;
   ////////////////////////////////////////////////////////////////////////
   // output fifo; capture writes are swallowed
   localparam int FW = 2 + 2 + 16 + 16 + 32;
   wire [FW-1:0] fifo_in = {res_sel, IN_KIND_IN, rid_sel, cid_sel, cap_sel};
   wire [FW-1:0] fifo_out;
   wire fifo_push = IN_VALID_IN && !(is_cap && CAP_WRITE_IN);
   wire fifo_wready;
   assign fifo_ready = fifo_wready || (is_cap && CAP_WRITE_IN);
   assign IN_READY_OUT = fifo_ready;
   ntrt_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .wr_data_in(fifo_in),
      .wr_valid_in(fifo_push),
      .wr_ready_out(fifo_wready),
      .rd_data_out(fifo_out),
      .rd_valid_out(OUT_VALID_OUT),
      .rd_ready_in(OUT_READY_IN)
   );
   assign OUT_RESULT_OUT = fifo_out[FW-1:FW-2];
   assign OUT_KIND_OUT = fifo_out[FW-3:FW-4];
   assign OUT_REQ_ID_OUT = fifo_out[63:48];
   assign OUT_CPL_ID_OUT = fifo_out[47:32];
   assign OUT_CAP_DATA_OUT = fifo_out[31:0];
endmodule // ntrt_translate
`default_nettype wire

/* pkg/ntrt_consts.svh */
`ifndef NTRT_CONSTS_SVH
`define NTRT_CONSTS_SVH
// mapping table entry field positions
`define NTRT_ENT_VALID 0
`define NTRT_ENT_FUNCTION_FIELD_LO 1
`define NTRT_ENT_FUNCTION_FIELD_HI 3
`define NTRT_ENT_DEV_LO 4
`define NTRT_ENT_DEV_HI 8
`define NTRT_ENT_BUS_LO 9
`define NTRT_ENT_BUS_HI 16
`define NTRT_ENT_PART_LO 17
`define NTRT_ENT_PART_HI 19
`define NTRT_ENT_WIDTH 20
// table size and translated id tags
`define NTRT_TABLE_DEPTH 64
`define NTRT_CPL_TAG 2'h2
`define NTRT_BYPASS_DEVFN 8'h03
// capture register reset value
`define NTRT_CAPTURE_RESET 32'h0000_0000
`endif

/* pkg/ntrt_pkg.sv */
package ntrt_pkg;
   typedef enum logic [1:0]
   {
      NTRT_KIND_POSTED = 2'h0,
      NTRT_KIND_NONPOSTED = 2'h1,
      NTRT_KIND_CPL = 2'h3,
      NTRT_KIND_CFGRD_CAP = 2'h2
   } ntrt_kind_type;
   typedef enum logic [1:0]
   {
      NTRT_RES_FWD = 2'h0,
      NTRT_RES_UR = 2'h1,
      NTRT_RES_UC = 2'h3,
      NTRT_RES_DROP = 2'h2
   } ntrt_result_type;
endpackage

/* rtl/ntrt_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module ntrt_fifo
   import ntrt_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wp_reg;
   logic [AW:0] rp_reg;
   wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   wire empty = (wp_reg == rp_reg);
   wire push = wr_valid_in && !full;
   wire pop = rd_ready_in && !empty;
   assign wr_ready_out = !full;
   assign rd_valid_out = !empty;
   assign rd_data_out = mem_reg[rp_reg[AW-1:0]];
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_reg[wp_reg[AW-1:0]] <= wr_data_in;
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         wp_reg <= '0;
         rp_reg <= '0;
      end
      else
      begin
         wp_reg <= wp_reg + (AW+1)'(push);
         rp_reg <= rp_reg + (AW+1)'(pop);
      end
   end
endmodule // ntrt_fifo
`default_nettype wire

/* sim/ntrt_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module ntrt_sink
(
   input wire logic clk_in,
   input wire logic stall_in,
   output logic ready_out
);
   // far side takes headers at once or holds them back while stalled
   initial ready_out = 1'b0;
   always @(negedge clk_in) ready_out <= !stall_in;
endmodule // ntrt_sink
`default_nettype wire

/* sim/ntrt_translate_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module ntrt_translate_checker
(
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic FUNCTION_FIELD_RESET_IN,
   input wire logic CPL_FWD_ENABLE_SET_IN,
   input wire logic [15:0] OWN_ID_IN,
   input wire logic [15:0] PUNCH_ID_IN,
   input wire logic PUNCH_ACTIVE_IN,
   input wire logic DST_BUS_MASTER_ENABLE_IN,
   input wire logic IN_VALID_IN,
   input wire logic IN_READY_OUT,
   input wire logic [1:0] IN_KIND_IN,
   input wire logic [15:0] IN_REQ_ID_IN,
   input wire logic CAP_WRITE_IN,
   input wire logic UR_PULSE_OUT,
   input wire logic UC_PULSE_OUT,
   input wire logic CPL_FWD_ENABLE_OUT,
   input wire logic [31:0] CAPTURE_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   wire tk = IN_VALID_IN && IN_READY_OUT;
   wire cpl = tk && IN_KIND_IN == 2'h3;
   wire cap = tk && IN_KIND_IN == 2'h2;
   ////////////////////////////////////////////////////////////////////////
   ur_bme_a:
      assert property (tk && !IN_KIND_IN[1] && !DST_BUS_MASTER_ENABLE_IN
         |=> UR_PULSE_OUT) else $error("unsupported flag missing");
   uc_punch_a:
      assert property (cpl && IN_REQ_ID_IN == PUNCH_ID_IN && !PUNCH_ACTIVE_IN
         |=> UC_PULSE_OUT) else $error("idle punch completion kept");
   uc_own_a:
      assert property (cpl && IN_REQ_ID_IN == OWN_ID_IN
         && IN_REQ_ID_IN != PUNCH_ID_IN |=> UC_PULSE_OUT)
         else $error("own id completion kept");
   uc_tag_a:
      assert property (cpl && IN_REQ_ID_IN[7:6] != 2'h2 && IN_REQ_ID_IN !=
         PUNCH_ID_IN |=> UC_PULSE_OUT) else $error("bad tag completion kept");
   err_excl_a:
      assert property (!(UR_PULSE_OUT && UC_PULSE_OUT))
         else $error("both error flags raised");
   fres_clr_a:
      assert property (FUNCTION_FIELD_RESET_IN && !CPL_FWD_ENABLE_SET_IN
         |=> !CPL_FWD_ENABLE_OUT) else $error("enable survives reset");
   capw_a:
      assert property (cap && CAP_WRITE_IN |=> $stable(CAPTURE_OUT)
         && !UR_PULSE_OUT && !UC_PULSE_OUT) else $error("capture write acted");
   capr_a:
      assert property (cap && !CAP_WRITE_IN |=> CAPTURE_OUT ==
         {16'h0, $past(IN_REQ_ID_IN)}) else $error("capture value wrong");
endmodule // ntrt_translate_checker
bind ntrt_translate ntrt_translate_checker u_ntrt_translate_checker (.*);
`default_nettype wire

/* sim/ntrt_translate_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ntrt_translate_tb_top
   import ntrt_pkg::*;
;
   logic CLK_IN, RSTN_IN, FUNCTION_FIELD_RESET_IN, TBL_WE_IN, PUNCH_ACTIVE_IN, stall;
   logic ID_CHECK_BYPASS_IN, CPL_FWD_ENABLE_SET_IN, CPL_FWD_ENABLE_CLR_IN;
   logic DST_BUS_MASTER_ENABLE_IN, IN_VALID_IN, CAP_WRITE_IN, OUT_READY_IN;
   logic IN_READY_OUT, OUT_VALID_OUT, UR_PULSE_OUT, UC_PULSE_OUT;
   logic CPL_FWD_ENABLE_OUT;
   logic [1:0] IN_KIND_IN, OUT_RESULT_OUT, OUT_KIND_OUT;
   logic [2:0] SRC_PART_IN;
   logic [5:0] TBL_ADDR_IN;
   logic [19:0] TBL_WDATA_IN;
   logic [15:0] OWN_ID_IN, PUNCH_ID_IN, DST_ID_IN, IN_REQ_ID_IN, IN_CPL_ID_IN;
   logic [15:0] OUT_REQ_ID_OUT, OUT_CPL_ID_OUT;
   logic [31:0] OUT_CAP_DATA_OUT, CAPTURE_OUT;
   int fail_count, check_count;
   ntrt_translate u_ntrt_translate (.*);
   ntrt_sink u_ntrt_sink (.clk_in(CLK_IN), .stall_in(stall),
      .ready_out(OUT_READY_IN));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic ent(logic [5:0] a, logic [19:0] d);
      TBL_ADDR_IN = a;
      TBL_WDATA_IN = d;
      TBL_WE_IN = 1'b1;
      @(negedge CLK_IN) TBL_WE_IN = 1'b0;
      @(negedge CLK_IN);
   endtask
   task automatic send(logic [1:0] k, logic [15:0] id);
      @(negedge CLK_IN);
      IN_KIND_IN = k;
      IN_REQ_ID_IN = id;
      IN_VALID_IN = 1'b1;
      @(posedge CLK_IN);
      while (IN_READY_OUT !== 1'b1) @(posedge CLK_IN);
      @(negedge CLK_IN) IN_VALID_IN = 1'b0;
   endtask
   task automatic res(ntrt_result_type r, logic [15:0] id);
      chk("valid", OUT_VALID_OUT, 1'b1);
      chk("result", OUT_RESULT_OUT, r);
      if (r == NTRT_RES_FWD)
         chk("req_id", OUT_REQ_ID_OUT, id);
      chk("ur", UR_PULSE_OUT, r == NTRT_RES_UR);
      chk("uc", UC_PULSE_OUT, r == NTRT_RES_UC);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_req;
      ent(6'h3f, {3'h1, 16'h1234, 1'b1});
      ent(6'h3e, {3'h1, 16'h5678, 1'b0});
      ent(6'h3d, {3'h1, 16'h1235, 1'b1});
      send(2'h1, 16'h1235);
      res(NTRT_RES_FWD, 16'habbd);
      send(2'h1, 16'h1234);
      res(NTRT_RES_FWD, 16'habbf);
      send(2'h1, 16'h5678);
      res(NTRT_RES_UR, 16'h0);
      SRC_PART_IN = 3'h2;
      send(2'h1, 16'h1234);
      res(NTRT_RES_UR, 16'h0);
      SRC_PART_IN = 3'h1;
      DST_BUS_MASTER_ENABLE_IN = 1'b0;
      send(2'h0, 16'h1234);
      res(NTRT_RES_UR, 16'h0);
      DST_BUS_MASTER_ENABLE_IN = 1'b1;
   endtask
   task automatic t_bypass;
      ID_CHECK_BYPASS_IN = 1'b1;
      send(2'h0, 16'h9999);
      res(NTRT_RES_FWD, 16'hab03);
      send(2'h1, 16'h9999);
      res(NTRT_RES_UR, 16'h0);
      ID_CHECK_BYPASS_IN = 1'b0;
   endtask
   task automatic t_cpl;
      send(2'h3, 16'h01bf);
      res(NTRT_RES_DROP, 16'h0);
      CPL_FWD_ENABLE_SET_IN = 1'b1;
      @(negedge CLK_IN) CPL_FWD_ENABLE_SET_IN = 1'b0;
      chk("cpl_en", CPL_FWD_ENABLE_OUT, 1'b1);
      send(2'h3, 16'h01bf);
      res(NTRT_RES_FWD, 16'h1234);
      chk("cpl_id", OUT_CPL_ID_OUT, 16'hab0c);
      send(2'h3, 16'h01be);
      res(NTRT_RES_UC, 16'h0);
      send(2'h3, 16'h00bf);
      res(NTRT_RES_UC, 16'h0);
      send(2'h3, 16'h02bf);
      res(NTRT_RES_UC, 16'h0);
      PUNCH_ACTIVE_IN = 1'b1;
      send(2'h3, 16'h02bf);
      chk("uc", UC_PULSE_OUT, 1'b0);
      PUNCH_ACTIVE_IN = 1'b0;
      FUNCTION_FIELD_RESET_IN = 1'b1;
      @(negedge CLK_IN) FUNCTION_FIELD_RESET_IN = 1'b0;
      chk("cpl_en", CPL_FWD_ENABLE_OUT, 1'b0);
      send(2'h3, 16'h01bf);
      res(NTRT_RES_DROP, 16'h0);
      CPL_FWD_ENABLE_SET_IN = 1'b1;
      @(negedge CLK_IN) CPL_FWD_ENABLE_SET_IN = 1'b0;
      CPL_FWD_ENABLE_CLR_IN = 1'b1;
      @(negedge CLK_IN) CPL_FWD_ENABLE_CLR_IN = 1'b0;
      chk("cpl_en", CPL_FWD_ENABLE_OUT, 1'b0);
      send(2'h3, 16'h01bf);
      res(NTRT_RES_DROP, 16'h0);
   endtask
   task automatic t_cap;
      send(2'h2, 16'h4321);
      chk("capture", CAPTURE_OUT, 32'h4321);
      res(NTRT_RES_FWD, 16'h4321);
      chk("cap_data", OUT_CAP_DATA_OUT, 32'h4321);
      chk("kind", OUT_KIND_OUT, 2'h2);
      CAP_WRITE_IN = 1'b1;
      send(2'h2, 16'h1111);
      chk("capture", CAPTURE_OUT, 32'h4321);
      chk("valid", OUT_VALID_OUT, 1'b0);
      CAP_WRITE_IN = 1'b0;
   endtask
   task automatic t_fifo;
      stall = 1'b1;
      repeat (16) send(2'h0, 16'h1234);
      chk("in_ready", IN_READY_OUT, 1'b0);
      stall = 1'b0;
      repeat (20) @(negedge CLK_IN);
      chk("valid", OUT_VALID_OUT, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial forever #25 CLK_IN = ~CLK_IN;
   initial
   begin
      #500000;
      fail_count++;
      finish_test;
   end
   initial
   begin
      {CLK_IN, RSTN_IN, FUNCTION_FIELD_RESET_IN, TBL_WE_IN, PUNCH_ACTIVE_IN, stall,
         ID_CHECK_BYPASS_IN, CPL_FWD_ENABLE_SET_IN, CPL_FWD_ENABLE_CLR_IN,
         IN_VALID_IN, CAP_WRITE_IN, IN_KIND_IN, TBL_ADDR_IN, TBL_WDATA_IN,
         IN_REQ_ID_IN, IN_CPL_ID_IN} = '0;
      SRC_PART_IN = 3'h1;
      DST_BUS_MASTER_ENABLE_IN = 1'b1;
      DST_ID_IN = 16'hab0c;
      OWN_ID_IN = 16'h00bf;
      PUNCH_ID_IN = 16'h02bf;
      repeat (10) @(negedge CLK_IN);
      RSTN_IN = 1'b1;
      t_req;
      t_bypass;
      t_cpl;
      t_cap;
      t_fifo;
      finish_test;
   end
endmodule // ntrt_translate_tb_top
`default_nettype wire
